// [logic/iwd_card_control.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iwd_defs.svh"

module iwd_card_control
    import iwd_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `IWD_TICK_CYCLES,
    parameter int unsigned TIMEOUT_TICKS = `IWD_TIMEOUT_TICKS,
    parameter int unsigned PULSE_CYCLES = `IWD_WDOG_PULSE_CYCLES,
    parameter int unsigned SOFT_RESET_CYCLES = `IWD_SOFT_RESET_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic ISA_RESET,
    input wire logic [15:0] ISA_ADDR,
    input wire logic [7:0] ISA_DATA_IN,
    input wire logic ISA_IOR_N,
    input wire logic ISA_IOW_N,
    input wire logic [7:0] UPPER_ADDRESS_SWITCH_BANK,
    input wire logic [2:0] LOWER_ADDRESS_SWITCH_BANK,
    input wire logic ADC_UNIPOLAR_FLAG,
    input wire logic ADC_CONVERTING_FLAG,
    input wire logic FOURTH_STATUS_FLAG,
    output logic [7:0] ISA_DATA_OUT,
    output logic ISA_DATA_OE,
    output logic CARD_RESET,
    output logic FAULT_LED,
    output logic DAC_OUTPUT_ENABLE,
    output logic WATCHDOG_ENABLED,
    output logic TIMEOUT_RESET_CONNECTOR_N
);

    initial begin
        if (TICK_CYCLES < 1) begin
            $error("iwd_card_control: TICK_CYCLES must be at least 1");
        end
        if (TIMEOUT_TICKS < 2) begin
            $error("iwd_card_control: TIMEOUT_TICKS must be at least 2");
        end
        if (PULSE_CYCLES < 1) begin
            $error("iwd_card_control: PULSE_CYCLES must be at least 1");
        end
        // The soft reset count is held in sixteen bits
        if (SOFT_RESET_CYCLES < 1 || SOFT_RESET_CYCLES > 16'hFFFF) begin
            $error("iwd_card_control: SOFT_RESET_CYCLES out of range");
        end
    end

    typedef struct packed {
        logic [2:0] isa_reset_sync;
        logic isa_reset_level;
        logic [2:0] ior_sync;
        logic [2:0] iow_sync;
        logic iow_seen;
        logic ior_seen;
        logic [15:0] addr_q;
        logic [7:0] data_q;
        logic [10:0] base_q;
        logic [2:0] flag_sync0;
        logic [2:0] flag_sync1;
        iwd_flags_type flags;
        iwd_flags_type flags_stable;
        logic [7:0] data_out;
        logic data_oe;
        logic [15:0] soft_count;
        logic card_reset;
        logic fault_led;
        logic dac_enable;
        iwd_wdog_state_type wstate;
        logic [31:0] tick_count;
        logic [31:0] wdog_ticks;
        logic [31:0] pulse_count;
        logic wdog_out_n;
        logic wdog_enabled;
    } iwd_state_type;

    iwd_state_type state;
    iwd_state_type next_state;

    // Level follows the last two stages only once they agree
    function automatic logic settled(input logic [2:0] s, input logic held);
        settled = (s[1] == s[2]) ? s[2] : held;
    endfunction

    function automatic logic hit(input logic [15:0] a, input logic [10:0] base, input logic [4:0] ofs);
        hit = (a[15:`IWD_BLOCK_BITS] == base) && (a[4:0] == ofs); // [R1]
    endfunction

    logic sys_reset;
    logic rd_edge;
    logic wr_edge;
    logic any_reset;

    always_comb begin
        sys_reset = settled(state.isa_reset_sync, state.isa_reset_level); // [R6]
        rd_edge = settled(state.ior_sync, state.ior_seen) && !state.ior_seen;
        wr_edge = settled(state.iow_sync, state.iow_seen) && !state.iow_seen;
        any_reset = sys_reset || state.soft_count != 16'h0000;
    end

    always_comb begin
        next_state = state;
        next_state.isa_reset_sync = {state.isa_reset_sync[1:0], ISA_RESET};
        next_state.isa_reset_level = sys_reset;
        next_state.ior_sync = {state.ior_sync[1:0], ~ISA_IOR_N};
        next_state.iow_sync = {state.iow_sync[1:0], ~ISA_IOW_N};
        next_state.ior_seen = settled(state.ior_sync, state.ior_seen);
        next_state.iow_seen = settled(state.iow_sync, state.iow_seen);
        next_state.addr_q = ISA_ADDR;
        next_state.data_q = ISA_DATA_IN;
        next_state.base_q = ~{UPPER_ADDRESS_SWITCH_BANK, LOWER_ADDRESS_SWITCH_BANK}; // [R2]
        next_state.flag_sync0 = {ADC_UNIPOLAR_FLAG, ADC_CONVERTING_FLAG, FOURTH_STATUS_FLAG};
        next_state.flag_sync1 = state.flag_sync0;
        next_state.flags = state.flag_sync1;
        // Status flags count once the second and third stages agree
        if (state.flag_sync1 == 3'(state.flags)) begin
            next_state.flags_stable = state.flags;
        end

        // Status read drives the bus while the read strobe lasts
        if (rd_edge && hit(state.addr_q, state.base_q, `IWD_OFS_STATUS)) begin
            next_state.data_out = {4'h0, state.flags_stable.adc_unipolar_flag, state.dac_enable,
                state.flags_stable.adc_converting_flag, state.flags_stable.fourth_status_flag}; // [R3] [R4]
            next_state.data_oe = 1'b1;
        end else if (!settled(state.ior_sync, state.ior_seen)) begin
            next_state.data_oe = 1'b0;
        end

        if (state.soft_count != 16'h0000) begin
            next_state.soft_count = state.soft_count - 16'h0001;
        end
        if (wr_edge && hit(state.addr_q, state.base_q, `IWD_OFS_SOFT_RESET)) begin
            next_state.soft_count = 16'(SOFT_RESET_CYCLES); // [R5]
        end
        next_state.card_reset = any_reset;
        next_state.fault_led = any_reset; // [R8]

        // Free-running local tick that paces the watchdog interval
        next_state.tick_count = (state.tick_count >= TICK_CYCLES - 1) ? 32'h0 : state.tick_count + 32'h1; // [R17]
        if (state.tick_count >= TICK_CYCLES - 1 && state.wdog_ticks != 32'hFFFFFFFF) begin
            next_state.wdog_ticks = state.wdog_ticks + 32'h1;
        end

        case (state.wstate)
            IWD_IDLE: begin
                next_state.wdog_out_n = 1'b1;
            end
            IWD_RUN: begin
                // Fires one tick after TIMEOUT_TICKS whole ticks, as the tick restarts at zero
                if (state.wdog_ticks >= TIMEOUT_TICKS + 1) begin // [R9]
                    next_state.wstate = IWD_FIRE;
                    next_state.wdog_out_n = 1'b0; // [R15]
                    next_state.pulse_count = 32'(PULSE_CYCLES - 1);
                end
            end
            IWD_FIRE: begin
                if (state.pulse_count == 32'h0) begin
                    next_state.wstate = IWD_IDLE; // [R16]
                    next_state.wdog_out_n = 1'b1;
                end else begin
                    next_state.pulse_count = state.pulse_count - 32'h1;
                end
            end
            default: begin
                next_state.wstate = IWD_IDLE;
            end
        endcase

        // A refresh while disabled or firing is ignored
        if (wr_edge && hit(state.addr_q, state.base_q, `IWD_OFS_REFRESH) && state.wstate == IWD_RUN) begin
            next_state.wdog_ticks = 32'h0; // [R14] [R17]
            next_state.tick_count = 32'h0;
        end
        if (wr_edge && hit(state.addr_q, state.base_q, `IWD_OFS_CONTROL)) begin
            next_state.dac_enable = state.data_q[`IWD_CTRL_DAC_BIT]; // [R12]
            if (state.data_q[`IWD_CTRL_WDOG_BIT]) begin
                if (state.wstate == IWD_IDLE) begin
                    next_state.wstate = IWD_RUN;
                    next_state.wdog_ticks = 32'h0; // [R17]
                    next_state.tick_count = 32'h0;
                end
            end else if (state.wstate == IWD_RUN) begin
                next_state.wstate = IWD_IDLE;
            end
        end

        // Either reset overrides any control or refresh write in the same cycle
        if (any_reset) begin
            next_state.wstate = IWD_IDLE; // [R7]
            next_state.dac_enable = 1'b0; // [R7]
            next_state.wdog_ticks = 32'h0;
            next_state.tick_count = 32'h0;
            next_state.wdog_out_n = 1'b1;
            next_state.data_oe = 1'b0;
        end
        // Registered so the enable output comes straight from a flip-flop
        next_state.wdog_enabled = next_state.wstate == IWD_RUN;
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= '0;
            state.wdog_out_n <= 1'b1;
            state.wstate <= IWD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        ISA_DATA_OUT = state.data_out;
        ISA_DATA_OE = state.data_oe;
        CARD_RESET = state.card_reset; // [R7]
        FAULT_LED = state.fault_led;
        DAC_OUTPUT_ENABLE = state.dac_enable;
        WATCHDOG_ENABLED = state.wdog_enabled;
        TIMEOUT_RESET_CONNECTOR_N = state.wdog_out_n;
    end

endmodule

`default_nettype wire

// [logic/iwd_defs.svh]
// Operation
// [R1] The card answers only I/O cycles whose address lies in one 32-byte block aligned to a 32-byte boundary.
// [R2] Base address bits 15..5 come from the switch banks, upper bank for 15..8 and lower bank for 7..5, with a switch on giving a zero.
// [R3] A read at offset 11 returns the status byte with four flags in the low nibble and the upper nibble don't-care.
// [R4] Status flags are active high: bit 3 unipolar, bit 2 all analog outputs enabled, bit 1 converter busy, bit 0 fourth flag.
// [R5] Any write to offset 11 resets this card only, whatever the data.
// [R6] The bus system reset resets the whole card with the same effect as a soft reset.
// [R7] Either reset disables the watchdog and analog outputs, clears encoder counters, selects encoder mode 0 and turns relays off.
// [R8] The fault indicator is on only while a system or local reset is in progress.
// [R9] An enabled watchdog does not time out sooner than 630 ms after enable or the latest refresh.
// [R10] The host refreshes an enabled watchdog at intervals of no more than 630 ms.
// [R11] The host makes the first refresh within 630 ms of enabling the watchdog.
// [R12] A write to offset 12 loads the watchdog enable from data bit 0 and the analog output enable from data bit 1.
// [R13] The host writes the analog output enable with its intended value whenever it changes the watchdog enable.
// [R14] Any write to offset 15 restarts the watchdog interval, whatever the data.
// [R15] On timeout the watchdog drives an active-low reset output for the system reset input.
// [R16] The timeout output is a low pulse of fixed width, after which the watchdog stays disabled until software enables it.
// [R17] The interval is counted from a free-running local time base, cleared on enable, refresh and any reset.
`ifndef IWD_DEFS_SVH
`define IWD_DEFS_SVH

`define IWD_BLOCK_BITS 5
`define IWD_OFS_STATUS 5'h0B
`define IWD_OFS_SOFT_RESET 5'h0B
`define IWD_OFS_CONTROL 5'h0C
`define IWD_OFS_REFRESH 5'h0F
`define IWD_CTRL_WDOG_BIT 0
`define IWD_CTRL_DAC_BIT 1
`define IWD_CLK_HZ 25000000
`define IWD_TIMEOUT_MS 630
`define IWD_TICK_US 1000
`define IWD_TICK_CYCLES ((`IWD_CLK_HZ / 1000000) * `IWD_TICK_US)
`define IWD_TIMEOUT_TICKS `IWD_TIMEOUT_MS
`define IWD_SOFT_RESET_CYCLES 16
`define IWD_WDOG_PULSE_CYCLES 250

`endif

// [logic/iwd_pkg.sv]
package iwd_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic rd;
        logic wr;
    } iwd_bus_type;

    typedef struct packed {
        logic adc_unipolar_flag;
        logic adc_converting_flag;
        logic fourth_status_flag;
    } iwd_flags_type;

    typedef enum logic [1:0] {
        IWD_IDLE,
        IWD_RUN,
        IWD_FIRE
    } iwd_wdog_state_type;

endpackage

// [verification/iwd_card_control_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module iwd_card_control_assertions #(
    parameter int unsigned TICK_CYCLES = 4,
    parameter int unsigned TIMEOUT_TICKS = 20
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic ISA_RESET,
    input wire logic ISA_IOW_N,
    input wire logic [7:0] ISA_DATA_OUT,
    input wire logic ISA_DATA_OE,
    input wire logic CARD_RESET,
    input wire logic FAULT_LED,
    input wire logic DAC_OUTPUT_ENABLE,
    input wire logic WATCHDOG_ENABLED,
    input wire logic TIMEOUT_RESET_CONNECTOR_N
);
    int unsigned quiet_cycles;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    // Cycles of an armed watchdog since the last write strobe
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            quiet_cycles <= 0;
        end else if (!ISA_IOW_N || !WATCHDOG_ENABLED || !TIMEOUT_RESET_CONNECTOR_N) begin
            quiet_cycles <= 0;
        end else begin
            quiet_cycles <= quiet_cycles + 1;
        end
    end
    sequence s_pulse_low;
        (!TIMEOUT_RESET_CONNECTOR_N) [*8];
    endsequence
    property p_fault; FAULT_LED == CARD_RESET; endproperty
    property p_sys_reset; $rose(ISA_RESET) |-> ##[1:5] CARD_RESET; endproperty
    property p_reset_state; CARD_RESET [*2] |-> !WATCHDOG_ENABLED && !DAC_OUTPUT_ENABLE; endproperty
    property p_not_early; $fell(TIMEOUT_RESET_CONNECTOR_N) |-> quiet_cycles + 8 >= TIMEOUT_TICKS * TICK_CYCLES;
    endproperty
    property p_not_late; quiet_cycles <= (TIMEOUT_TICKS + 2) * TICK_CYCLES + 8; endproperty
    property p_pulse; $fell(TIMEOUT_RESET_CONNECTOR_N) |-> s_pulse_low ##[1:4] TIMEOUT_RESET_CONNECTOR_N; endproperty
    property p_off_after; $rose(TIMEOUT_RESET_CONNECTOR_N) |-> ##1 (!WATCHDOG_ENABLED) [*3]; endproperty
    property p_status; $rose(ISA_DATA_OE) |-> ISA_DATA_OUT[7:4] == 4'h0 && ISA_DATA_OUT[2] == DAC_OUTPUT_ENABLE;
    endproperty
    a_fault: assert property (p_fault) else $error("fault led differs from card reset");
    a_sys_reset: assert property (p_sys_reset) else $error("bus reset not applied");
    a_reset_state: assert property (p_reset_state) else $error("enables set during reset");
    a_not_early: assert property (p_not_early) else $error("timeout too early");
    a_not_late: assert property (p_not_late) else $error("timeout missing");
    a_pulse: assert property (p_pulse) else $error("timeout pulse width wrong");
    a_off_after: assert property (p_off_after) else $error("watchdog still armed after pulse");
    a_status: assert property (p_status) else $error("status byte wrong");
endmodule
bind iwd_card_control iwd_card_control_assertions #(.TICK_CYCLES(TICK_CYCLES), .TIMEOUT_TICKS(TIMEOUT_TICKS))
    iwd_card_control_assertions_inst (.CLK_SYS, .RESET_N, .ISA_RESET, .ISA_IOW_N, .ISA_DATA_OUT, .ISA_DATA_OE,
    .CARD_RESET, .FAULT_LED, .DAC_OUTPUT_ENABLE, .WATCHDOG_ENABLED, .TIMEOUT_RESET_CONNECTOR_N);
`default_nettype wire

// [verification/iwd_isa_host.sv]
`timescale 1ns/1ps
`default_nettype none
module iwd_isa_host (
    input wire logic clk,
    output logic [15:0] addr,
    output logic [7:0] data,
    output logic ior_n,
    output logic iow_n,
    input wire logic [8:0] rdata
);
    initial begin
        addr = 16'h0000;
        data = 8'h00;
        ior_n = 1'b1;
        iow_n = 1'b1;
    end
    // One I/O cycle: strobe low six clocks, bus inverted once released
    task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic rd, output logic [8:0] q);
        @(negedge clk);
        addr = a;
        data = d;
        ior_n = !rd;
        iow_n = rd;
        repeat (6) @(posedge clk);
        @(negedge clk);
        q = rdata;
        ior_n = 1'b1;
        iow_n = 1'b1;
        addr = ~a;
        data = ~d;
        repeat (5) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// [verification/test_iwd_card_control.sv]
`timescale 1ns/1ps
`default_nettype none
module test_iwd_card_control;
    localparam logic [15:0] BASE = 16'h03A0;
    logic CLK_SYS = 1'b0;
    logic RESET_N = 1'b0;
    logic ISA_RESET = 1'b0;
    logic [2:0] flags = 3'b101;
    logic [7:0] sw_hi = 8'hFC;
    logic [2:0] sw_lo = 3'h2;
    logic [15:0] addr;
    logic [7:0] wdata, dout;
    logic ior_n, iow_n, oe, card_reset, fault, dac, wden, to_n;
    logic [8:0] q;
    int num_errors = 0;
    int total_checks = 0;
    int i;
    initial begin
        forever #20 CLK_SYS = ~CLK_SYS;
    end
    iwd_isa_host iwd_isa_host_inst (.clk(CLK_SYS), .addr(addr), .data(wdata), .ior_n(ior_n), .iow_n(iow_n),
        .rdata({oe, dout}));
    iwd_card_control #(.TICK_CYCLES(4), .TIMEOUT_TICKS(20), .PULSE_CYCLES(10)) iwd_card_control_inst (
        .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .ISA_RESET(ISA_RESET), .ISA_ADDR(addr), .ISA_DATA_IN(wdata),
        .ISA_IOR_N(ior_n), .ISA_IOW_N(iow_n), .UPPER_ADDRESS_SWITCH_BANK(sw_hi), .LOWER_ADDRESS_SWITCH_BANK(sw_lo),
        .ADC_UNIPOLAR_FLAG(flags[2]), .ADC_CONVERTING_FLAG(flags[1]), .FOURTH_STATUS_FLAG(flags[0]),
        .ISA_DATA_OUT(dout), .ISA_DATA_OE(oe), .CARD_RESET(card_reset), .FAULT_LED(fault),
        .DAC_OUTPUT_ENABLE(dac), .WATCHDOG_ENABLED(wden), .TIMEOUT_RESET_CONNECTOR_N(to_n));
    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] ofs, input logic [7:0] d);
        iwd_isa_host_inst.cycle(BASE | {11'h000, ofs}, d, 1'b0, q);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Selector 0 waits on card reset, 1 on the timeout output
    task automatic wait_for(input int sel, input logic val);
        for (i = 0; i < 400; i++) begin
            @(negedge CLK_SYS);
            if ((sel == 0 ? card_reset : to_n) === val) break;
        end
        if (i == 400) begin
            num_errors++;
            end_of_test;
        end
    endtask
    initial begin
        repeat (16) @(negedge CLK_SYS);
        RESET_N = 1'b1;
        chk("idle outputs", 9'h001, {wden, dac, fault, to_n});
        wr(5'h0C, 8'h02);
        chk("analog enable", 9'h001, dac);
        for (int k = 0; k < 2; k++) begin
            flags = k ? 3'b010 : 3'b101;
            repeat (4) @(negedge CLK_SYS);
            iwd_isa_host_inst.cycle(BASE | 16'h000B, 8'h00, 1'b1, q);
            chk("status", {5'h10, flags[2], 1'b1, flags[1:0]}, q);
        end
        iwd_isa_host_inst.cycle((BASE ^ 16'h0020) | 16'h000B, 8'h00, 1'b1, q);
        chk("foreign read", 9'h000, q[8]);
        sw_lo = 3'h3;
        repeat (4) @(negedge CLK_SYS);
        iwd_isa_host_inst.cycle((BASE ^ 16'h0020) | 16'h000B, 8'h00, 1'b1, q);
        chk("moved base read", 9'h001, q[8]);
        sw_lo = 3'h2;
        $display("test status done");
        wr(5'h0C, 8'h03);
        chk("armed before soft reset", 9'h003, {wden, dac});
        wr(5'h0B, 8'hFF);
        wait_for(0, 1'b1);
        chk("fault on", 9'h001, fault);
        wait_for(0, 1'b0);
        chk("after soft reset", 9'h000, {wden, dac, fault});
        $display("test soft reset done");
        wr(5'h0C, 8'h03);
        ISA_RESET = 1'b1;
        wait_for(0, 1'b1);
        repeat (20) @(negedge CLK_SYS);
        chk("held reset", 9'h003, {card_reset, fault});
        ISA_RESET = 1'b0;
        wait_for(0, 1'b0);
        chk("after bus reset", 9'h000, {wden, dac, fault});
        $display("test bus reset done");
        wr(5'h0C, 8'h03);
        chk("armed", 9'h003, {wden, dac});
        for (int k = 0; k < 4; k++) begin
            repeat (40) @(negedge CLK_SYS);
            wr(5'h0F, 8'hA5);
            chk("no timeout", 9'h001, to_n);
        end
        wait_for(1, 1'b0);
        wait_for(1, 1'b1);
        chk("disarmed", 9'h000, wden);
        $display("test watchdog done");
        end_of_test;
    end
endmodule
`default_nettype wire
